// *** core/tfr_params.svh ***
`ifndef TFR_PARAMS_SVH
`define TFR_PARAMS_SVH

// Command codes decoded on the management bus.
`define TFR_CMD_CLEAR_FAULTS   8'h03
`define TFR_CMD_STATUS_WORD    8'h79
`define TFR_CMD_STATUS_TEMP    8'h7D
`define TFR_CMD_VENDOR_STATUS  8'h80
`define TFR_CMD_OTF_THRESHOLD  8'h4F
`define TFR_CMD_FAULT_ACTION   8'h50
`define TFR_CMD_OTW_THRESHOLD  8'h51
`define TFR_CMD_UTW_THRESHOLD  8'h52

// Reset values of the stored settings.
`define TFR_RST_FAULT_ACTION   8'h80
`define TFR_RST_OTW_THRESHOLD  16'hEB70
`define TFR_RST_UTW_THRESHOLD  16'hDC40
`define TFR_RST_OTF_THRESHOLD  16'hEBE8

// Fields of the fault action byte.
`define TFR_ACT_MODE_HI        7
`define TFR_ACT_MODE_LO        6
`define TFR_ACT_RETRY_HI       5
`define TFR_ACT_RETRY_LO       3
`define TFR_ACT_DELAY_HI       2
`define TFR_ACT_DELAY_LO       0
`define TFR_ACT_MODE_DISABLE   2'h2

// Bit positions in the status registers.
`define TFR_ST_OVERTEMP_FAULT_BIT        7
`define TFR_ST_OT_WARN         6
`define TFR_ST_UT_WARN         5
`define TFR_SW_TEMPERATURE     2
`define TFR_VS_OVERTEMP_FAULT_BIT        1

// Accepted limit ranges in sixteenths of a degree Celsius.
`define TFR_OT_MIN_Q4          32'sh0
`define TFR_OT_MAX_Q4          32'sh0AF0
`define TFR_UT_MIN_Q4          -32'sh0370
`define TFR_UT_MAX_Q4          32'sh0190

// Retry time unit.
`define TFR_CLK_HZ             10000000
`define TFR_RETRY_UNIT_MS      35
`define TFR_RETRY_UNIT_CYCLES  ((`TFR_RETRY_UNIT_MS * `TFR_CLK_HZ) / 1000)

// Bus address of this device; the value is arbitrary.
`define TFR_BUS_ADDR           7'h2A

`endif

// *** core/tfr_pkg.sv ***
package tfr_pkg;

  // Output control states, Gray coded along run, delay, cool, latched.
  typedef enum logic [1:0] {
    TFR_RUN     = 2'h0,
    TFR_DELAY   = 2'h1,
    TFR_COOL    = 2'h3,
    TFR_LATCHED = 2'h2
  } tfr_ctl_t;

  // Bus slave states, Gray coded along address, command, data.
  typedef enum logic [2:0] {
    TFR_SL_IDLE = 3'h0,
    TFR_SL_ADDR = 3'h1,
    TFR_SL_CMD  = 3'h3,
    TFR_SL_WDAT = 3'h2,
    TFR_SL_RDAT = 3'h6,
    TFR_SL_SKIP = 3'h4
  } tfr_sl_t;

  // Converts an exponent and mantissa word to sixteenths of a degree.
  function automatic logic signed [31:0] tfr_lin11_q4(input logic [15:0] w);
    logic signed [4:0]  n;
    logic signed [31:0] y;
    logic signed [5:0]  s;
    n = w[15:11];
    y = {{21{w[10]}}, w[10:0]};
    s = 6'(n) + 6'sd4;
    if (s >= 0) begin
      tfr_lin11_q4 = y <<< s;
    end else begin
      tfr_lin11_q4 = y >>> (-s);
    end
  endfunction

endpackage

// *** core/tfr_bus_slave.sv ***
`timescale 1ns/10ps
`include "tfr_params.svh"

// Samples the two-wire management bus and turns it into write strobes and read loads.
module tfr_bus_slave
  import tfr_pkg::*;
(
  // Clock and reset.
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  // Bus pins.
  input  wire logic        scl,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // Transaction side.
  output logic             wr_strobe,
  output logic [7:0]       wr_cmd,
  output logic [15:0]      wr_data,
  output logic [1:0]       wr_len,
  input  wire logic [15:0] rd_data
);

  logic [2:0]  scl_s;
  logic [2:0]  sda_s;
  tfr_sl_t     state, next_state;
  logic [3:0]  cnt, next_cnt;
  logic [7:0]  rx, next_rx;
  logic [7:0]  tx, next_tx;
  logic        hi_byte, next_hi_byte;
  logic        mack, next_mack;
  logic        pend, next_pend;
  logic        next_oe;
  logic        next_strobe;
  logic [7:0]  next_cmd;
  logic [15:0] next_data;
  logic [1:0]  next_len;
  logic        rise, fall, start, stop;

  // Two flip-flops synchronise each pin; the third stage only serves edge detection.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
    end else begin
      scl_s <= {scl_s[1:0], scl};
      sda_s <= {sda_s[1:0], sda_in};
    end
  end

  // Edges and bus conditions seen on the synchronised pins.
  assign rise  = scl_s[1] & ~scl_s[2];
  assign fall  = ~scl_s[1] & scl_s[2];
  assign start = scl_s[1] & scl_s[2] & sda_s[2] & ~sda_s[1];
  assign stop  = scl_s[1] & scl_s[2] & ~sda_s[2] & sda_s[1];

  // Bit and byte sequencing, acknowledge and read data drive.
  always_comb begin
    next_state   = state;
    next_cnt     = cnt;
    next_rx      = rx;
    next_tx      = tx;
    next_hi_byte = hi_byte;
    next_mack    = mack;
    next_pend    = pend;
    next_oe      = sda_oe;
    next_strobe  = 1'b0;
    next_cmd     = wr_cmd;
    next_data    = wr_data;
    next_len     = wr_len;
    if (start || stop) begin
      next_strobe = pend;
      next_pend   = 1'b0;
      next_oe     = 1'b0;
      next_cnt    = 4'h0;
      next_state  = start ? TFR_SL_ADDR : TFR_SL_IDLE;
    end else if (state != TFR_SL_IDLE && state != TFR_SL_SKIP) begin
      if (rise) begin
        if (cnt < 4'h8) begin
          next_rx = {rx[6:0], sda_s[1]};
        end else if (cnt == 4'h8) begin
          next_mack = ~sda_s[1];
        end
        next_cnt = cnt + 4'h1;
      end else if (fall) begin
        if (cnt == 4'h8) begin
          next_oe = 1'b1;
          case (state)
            TFR_SL_ADDR: begin
              if (rx[7:1] != `TFR_BUS_ADDR) begin
                next_oe    = 1'b0;
                next_state = TFR_SL_SKIP;
              end
            end
            TFR_SL_CMD: begin
              next_cmd  = rx;
              next_len  = 2'h0;
              next_pend = 1'b1;
            end
            TFR_SL_WDAT: begin
              if (wr_len == 2'h0) begin
                next_data[7:0] = rx;
              end else begin
                next_data[15:8] = rx;
              end
              if (wr_len != 2'h2) begin
                next_len = wr_len + 2'h1;
              end
            end
            default: begin
              next_oe = 1'b0;
            end
          endcase
        end else if (cnt == 4'h9) begin
          next_cnt = 4'h0;
          next_oe  = 1'b0;
          case (state)
            TFR_SL_ADDR: begin
              if (rx[0]) begin
                next_state   = TFR_SL_RDAT;
                next_hi_byte = 1'b0;
                next_tx      = rd_data[7:0];
                next_oe      = ~rd_data[7];
              end else begin
                next_state = TFR_SL_CMD;
              end
            end
            TFR_SL_CMD: begin
              next_state = TFR_SL_WDAT;
            end
            TFR_SL_RDAT: begin
              if (mack && !hi_byte) begin
                next_hi_byte = 1'b1;
                next_tx      = rd_data[15:8];
                next_oe      = ~rd_data[15];
              end else begin
                next_state = TFR_SL_SKIP;
              end
            end
            default: begin
              next_state = state;
            end
          endcase
        end else if (state == TFR_SL_RDAT) begin
          next_oe = ~tx[3'(4'h7 - cnt)];
        end
      end
    end
  end

  // Registers the slave state.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state     <= TFR_SL_IDLE;
      cnt       <= 4'h0;
      rx        <= 8'h00;
      tx        <= 8'h00;
      hi_byte   <= 1'b0;
      mack      <= 1'b0;
      pend      <= 1'b0;
      sda_oe    <= 1'b0;
      sda_out   <= 1'b0;
      wr_strobe <= 1'b0;
      wr_cmd    <= 8'h00;
      wr_data   <= 16'h0000;
      wr_len    <= 2'h0;
    end else begin
      state     <= next_state;
      cnt       <= next_cnt;
      rx        <= next_rx;
      tx        <= next_tx;
      hi_byte   <= next_hi_byte;
      mack      <= next_mack;
      pend      <= next_pend;
      sda_oe    <= next_oe;
      sda_out   <= 1'b0;
      wr_strobe <= next_strobe;
      wr_cmd    <= next_cmd;
      wr_data   <= next_data;
      wr_len    <= next_len;
    end
  end

endmodule

// *** core/tfr_top.sv ***
`timescale 1ns/10ps
`include "tfr_params.svh"

////////////////////////////////////////
// Overview of operation
// - Over-temperature fault action is taken only when the action mode bits 7:6 read 10.
// - An over-temperature fault pulls the alert line low and sets its status fault bit.
// - Fault status bits stay set until the clear-faults command and nothing else clears them.
// - With retry field 000 the output stays off after the fault until the fault is cleared.
// - With retry field 001 to 111 restarts repeat until enable, operation, bias or another fault stops them.
// - A retry does not begin until a sample is below the over-temperature warning threshold.
// - Restart attempts are spaced by the delay field plus one times 35 ms.
// - A warning crossing sets the status word temperature bit, the warning bit, and raises the alert.
// - Each limit word is a signed exponent in bits 15:11 and a signed mantissa in bits 10:0.
// - Written limits outside their allowed range are refused and the old value is kept.
// - While the under-temperature response retries, restart waits for a sample above its warning threshold.
// - Exceeding the fault threshold sets the fault bit and bit 1 of the vendor status byte.
////////////////////////////////////////

module tfr_top
  import tfr_pkg::*;
#(
  parameter int RETRY_UNIT_CYCLES = `TFR_RETRY_UNIT_CYCLES
)
(
  // Clock and reset.
  input  wire logic               ref_clk,
  input  wire logic               resetn,
  // Management bus.
  input  wire logic               scl,
  input  wire logic               sda_in,
  output logic                    sda_out,
  output logic                    sda_oe,
  // Temperature samples in sixteenths of a degree.
  input  wire logic signed [15:0] temp_q4,
  input  wire logic               temp_valid,
  // Run control.
  input  wire logic               enable_pin,
  input  wire logic               bias_ok,
  input  wire logic               operation_on,
  input  wire logic               other_fault,
  input  wire logic               ut_retry_active,
  // Results.
  output logic                    output_on,
  output logic                    alert_line_n
);

  logic        wr_strobe;
  logic [7:0]  wr_cmd;
  logic [15:0] wr_data;
  logic [1:0]  wr_len;
  logic [15:0] rd_data, next_rd_data;
  logic [1:0]  en_sync;
  logic [1:0]  bias_sync;

  logic [7:0]  overtemp_fault_action, next_action;
  logic [15:0] overtemp_warning_threshold, next_otw;
  logic [15:0] undertemp_warning_threshold, next_utw;
  logic [15:0] overtemp_fault_threshold, next_otf;
  logic        st_overtemp_fault_bit, next_st_overtemp_fault_bit;
  logic        st_ot_warn, next_st_ot_warn;
  logic        st_ut_warn, next_st_ut_warn;
  logic        st_temp_sum, next_st_temp_sum;
  logic        vs_overtemp_fault_bit, next_vs_overtemp_fault_bit;
  logic        below_otw, next_below_otw;
  logic        above_utw, next_above_utw;

  tfr_ctl_t    state, next_state;
  logic [18:0] tick, next_tick;
  logic [2:0]  units, next_units;
  logic        next_output_on;
  logic        next_alert_n;

  logic signed [31:0] samp, otw_q4, utw_q4, otf_q4, wr_q4;
  logic               clear_cmd, overtemp_fault_bit_evt, ot_warn_evt, ut_warn_evt, stop_retry, cool_ok;

  // Bus front end.
  tfr_bus_slave u_slave (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .scl       (scl),
    .sda_in    (sda_in),
    .sda_out   (sda_out),
    .sda_oe    (sda_oe),
    .wr_strobe (wr_strobe),
    .wr_cmd    (wr_cmd),
    .wr_data   (wr_data),
    .wr_len    (wr_len),
    .rd_data   (rd_data)
  );

  ////////////////////////////////////////
  // Pin synchronisers for the enable and bias pins.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      en_sync   <= 2'h0;
      bias_sync <= 2'h0;
    end else begin
      en_sync   <= {en_sync[0], enable_pin};
      bias_sync <= {bias_sync[0], bias_ok};
    end
  end

  ////////////////////////////////////////
  // Limits in a common fixed-point scale, and sample comparisons.
  assign samp      = 32'(temp_q4);
  assign otw_q4    = tfr_lin11_q4(overtemp_warning_threshold);
  assign utw_q4    = tfr_lin11_q4(undertemp_warning_threshold);
  assign otf_q4    = tfr_lin11_q4(overtemp_fault_threshold);
  assign wr_q4     = tfr_lin11_q4(wr_data);
  assign ot_warn_evt  = temp_valid && (samp > otw_q4);
  assign ut_warn_evt  = temp_valid && (samp < utw_q4);
  assign overtemp_fault_bit_evt = temp_valid && (samp > otf_q4);
  assign clear_cmd = wr_strobe && (wr_cmd == `TFR_CMD_CLEAR_FAULTS) && (wr_len == 2'h0);
  assign stop_retry = !en_sync[1] || !operation_on || !bias_sync[1] || other_fault;
  assign cool_ok    = below_otw && (!ut_retry_active || above_utw);

  ////////////////////////////////////////
  // Settings writes with range checks, sticky status, and read data selection.
  always_comb begin
    next_action      = overtemp_fault_action;
    next_otw         = overtemp_warning_threshold;
    next_utw         = undertemp_warning_threshold;
    next_otf         = overtemp_fault_threshold;
    next_below_otw   = below_otw;
    next_above_utw   = above_utw;
    if (wr_strobe && wr_len != 2'h0 && wr_cmd == `TFR_CMD_FAULT_ACTION) begin
      next_action = wr_data[7:0];
    end
    if (wr_strobe && wr_len == 2'h2) begin
      // Out-of-range limit words are dropped here and the old value stays.
      if (wr_cmd == `TFR_CMD_OTW_THRESHOLD && wr_q4 >= `TFR_OT_MIN_Q4 && wr_q4 <= `TFR_OT_MAX_Q4) begin
        next_otw = wr_data;
      end
      if (wr_cmd == `TFR_CMD_UTW_THRESHOLD && wr_q4 >= `TFR_UT_MIN_Q4 && wr_q4 <= `TFR_UT_MAX_Q4) begin
        next_utw = wr_data;
      end
      if (wr_cmd == `TFR_CMD_OTF_THRESHOLD && wr_q4 >= `TFR_OT_MIN_Q4 && wr_q4 <= `TFR_OT_MAX_Q4) begin
        next_otf = wr_data;
      end
    end
    if (temp_valid) begin
      next_below_otw = samp < otw_q4;
      next_above_utw = samp > utw_q4;
    end
    // Set wins over clear so that an event in the clearing cycle is kept.
    next_st_ot_warn  = ot_warn_evt || (st_ot_warn && !clear_cmd);
    next_st_ut_warn  = ut_warn_evt || (st_ut_warn && !clear_cmd);
    next_st_overtemp_fault_bit = overtemp_fault_bit_evt || (st_overtemp_fault_bit && !clear_cmd);
    next_vs_overtemp_fault_bit = overtemp_fault_bit_evt || (vs_overtemp_fault_bit && !clear_cmd);
    next_st_temp_sum = ot_warn_evt || ut_warn_evt || overtemp_fault_bit_evt || (st_temp_sum && !clear_cmd);
    next_alert_n     = !(next_st_ot_warn || next_st_ut_warn || next_st_overtemp_fault_bit);
    case (wr_cmd)
      `TFR_CMD_FAULT_ACTION:  next_rd_data = {8'h00, overtemp_fault_action};
      `TFR_CMD_OTW_THRESHOLD: next_rd_data = overtemp_warning_threshold;
      `TFR_CMD_UTW_THRESHOLD: next_rd_data = undertemp_warning_threshold;
      `TFR_CMD_OTF_THRESHOLD: next_rd_data = overtemp_fault_threshold;
      `TFR_CMD_STATUS_TEMP:   next_rd_data = {8'h00, st_overtemp_fault_bit, st_ot_warn, st_ut_warn, 5'h00};
      `TFR_CMD_STATUS_WORD:   next_rd_data = {13'h0000, st_temp_sum, 2'h0};
      `TFR_CMD_VENDOR_STATUS: next_rd_data = {14'h0000, vs_overtemp_fault_bit, 1'b0};
      default:                next_rd_data = 16'h0000;
    endcase
  end

  // Registers settings, status and read data.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      overtemp_fault_action       <= `TFR_RST_FAULT_ACTION;
      overtemp_warning_threshold  <= `TFR_RST_OTW_THRESHOLD;
      undertemp_warning_threshold <= `TFR_RST_UTW_THRESHOLD;
      overtemp_fault_threshold    <= `TFR_RST_OTF_THRESHOLD;
      st_overtemp_fault_bit                 <= 1'b0;
      st_ot_warn                  <= 1'b0;
      st_ut_warn                  <= 1'b0;
      st_temp_sum                 <= 1'b0;
      vs_overtemp_fault_bit                 <= 1'b0;
      below_otw                   <= 1'b0;
      above_utw                   <= 1'b0;
      alert_line_n                <= 1'b1;
      rd_data                     <= 16'h0000;
    end else begin
      overtemp_fault_action       <= next_action;
      overtemp_warning_threshold  <= next_otw;
      undertemp_warning_threshold <= next_utw;
      overtemp_fault_threshold    <= next_otf;
      st_overtemp_fault_bit                 <= next_st_overtemp_fault_bit;
      st_ot_warn                  <= next_st_ot_warn;
      st_ut_warn                  <= next_st_ut_warn;
      st_temp_sum                 <= next_st_temp_sum;
      vs_overtemp_fault_bit                 <= next_vs_overtemp_fault_bit;
      below_otw                   <= next_below_otw;
      above_utw                   <= next_above_utw;
      alert_line_n                <= next_alert_n;
      rd_data                     <= next_rd_data;
    end
  end

  ////////////////////////////////////////
  // Fault response: latch off, or wait out the retry delay and cool down before restart.
  always_comb begin
    next_state = state;
    next_tick  = tick;
    next_units = units;
    case (state)
      TFR_RUN: begin
        if (overtemp_fault_bit_evt &&
            overtemp_fault_action[`TFR_ACT_MODE_HI:`TFR_ACT_MODE_LO] == `TFR_ACT_MODE_DISABLE) begin
          next_tick  = 19'h00000;
          next_units = overtemp_fault_action[`TFR_ACT_DELAY_HI:`TFR_ACT_DELAY_LO];
          if (overtemp_fault_action[`TFR_ACT_RETRY_HI:`TFR_ACT_RETRY_LO] == 3'h0) begin
            next_state = TFR_LATCHED;
          end else begin
            next_state = TFR_DELAY;
          end
        end
      end
      TFR_LATCHED: begin
        if (clear_cmd) begin
          next_state = TFR_RUN;
        end
      end
      TFR_DELAY: begin
        // Delay field plus one whole units elapse before the cooling check.
        if (stop_retry) begin
          next_state = TFR_RUN;
        end else if (tick == 19'(RETRY_UNIT_CYCLES - 1)) begin
          next_tick = 19'h00000;
          if (units == 3'h0) begin
            next_state = TFR_COOL;
          end else begin
            next_units = units - 3'h1;
          end
        end else begin
          next_tick = tick + 19'h00001;
        end
      end
      TFR_COOL: begin
        if (stop_retry || cool_ok) begin
          next_state = TFR_RUN;
        end
      end
      default: begin
        next_state = TFR_RUN;
      end
    endcase
    next_output_on = (next_state == TFR_RUN) && !stop_retry;
  end

  // Registers the fault response state.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state     <= TFR_RUN;
      tick      <= 19'h00000;
      units     <= 3'h0;
      output_on <= 1'b0;
    end else begin
      state     <= next_state;
      tick      <= next_tick;
      units     <= next_units;
      output_on <= next_output_on;
    end
  end

endmodule

// *** bench/tfr_top_sva.sv ***
`timescale 1ns/10ps

// Checks alert, output and bus timing at the block's pins.
module tfr_top_sva (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic resetn,
  // Management bus.
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_oe,
  // Samples and run control.
  input wire logic temp_valid,
  input wire logic enable_pin,
  input wire logic bias_ok,
  input wire logic operation_on,
  input wire logic other_fault,
  // Results.
  input wire logic output_on,
  input wire logic alert_line_n
);
  logic [2:0] ok_cnt, next_ok_cnt;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  ////////////////////////////////////////
  // Counts cycles with all run conditions present.
  always_comb begin
    next_ok_cnt = 3'h0;
    if (operation_on && enable_pin && bias_ok && !other_fault) begin
      next_ok_cnt = (ok_cnt == 3'h7) ? 3'h7 : ok_cnt + 3'h1;
    end
  end

  // Registers the run counter.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ok_cnt <= 3'h0;
    end else begin
      ok_cnt <= next_ok_cnt;
    end
  end

  ////////////////////////////////////////
  // Timing relations at the pins.
  AST_RESET_QUIET: assert property ($rose(resetn) |-> alert_line_n && !output_on && !sda_oe)
    else $error("outputs not idle after reset");
  AST_RUN_CAUSE: assert property ($rose(output_on) |-> $past(operation_on) && !$past(other_fault))
    else $error("output started without run conditions");
  AST_ALERT_CLEAR_ONLY: assert property ($rose(alert_line_n) |-> scl && sda_in && $past(scl, 4))
    else $error("alert released outside a bus stop");
  AST_ALERT_FROM_SAMPLE: assert property ($fell(alert_line_n) |-> $past(temp_valid) || $past(temp_valid, 2))
    else $error("alert raised without a sample");
  AST_OFF_CAUSE: assert property ($fell(output_on) && ok_cnt == 3'h7 |-> $past(temp_valid))
    else $error("output dropped without a sample");
  AST_OFF_ALERTS: assert property ($fell(output_on) && ok_cnt == 3'h7 |-> ##[0:2] !alert_line_n)
    else $error("fault shutdown without alert");
  AST_OFF_MIN: assert property ($fell(output_on) && ok_cnt == 3'h7 |->
    !output_on [*8] ##1 !output_on [*8] ##1 !output_on [*3])
    else $error("restart before the retry delay");
  AST_ACK_HOLD: assert property ($rose(sda_oe) |-> sda_oe [*6])
    else $error("acknowledge too short");
endmodule

bind tfr_top tfr_top_sva u_tfr_top_sva (.ref_clk(ref_clk), .resetn(resetn), .scl(scl), .sda_in(sda_in),
  .sda_oe(sda_oe), .temp_valid(temp_valid), .enable_pin(enable_pin), .bias_ok(bias_ok),
  .operation_on(operation_on), .other_fault(other_fault), .output_on(output_on), .alert_line_n(alert_line_n));

// *** bench/tfr_host_model.sv ***
`timescale 1ns/10ps
`include "tfr_params.svh"

// Bus host; its clock stands high between frames and it releases data to the pull-up.
module tfr_host_model
  import tfr_pkg::*;
(
  // Clock.
  input  wire logic ref_clk,
  // Bus pins.
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda_line
);
  // Idle bus with both lines released.
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  // Waits a number of device clock cycles.
  task automatic w(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // One 800 ns bit: data moves after the clock falls, the line is read while it is high.
  task automatic bit_io(input logic b, output logic r);
    w(1);
    sda_drv <= b;
    w(3);
    scl <= 1'b1;
    w(3);
    r = sda_line;
    w(1);
    scl <= 1'b0;
  endtask

  // Start or repeated start.
  task automatic start();
    w(1);
    sda_drv <= 1'b1;
    w(3);
    scl <= 1'b1;
    w(4);
    sda_drv <= 1'b0;
    w(4);
    scl <= 1'b0;
  endtask

  // Eight bits then the answer bit.
  task automatic xbyte(input logic [7:0] d, input logic ack_in, output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
    bit_io(ack_in, ack);
  endtask

  // Write of nb bytes low first, or a word read; nak collects refused address and command bytes.
  task automatic xfer(input logic [7:0] cmd, input logic [15:0] d, input int nb, input logic rd,
                      output logic [15:0] q, output logic nak);
    logic [7:0] lo, hi, t;
    logic       a, b;
    start();
    xbyte({`TFR_BUS_ADDR, 1'b0}, 1'b1, t, a);
    xbyte(cmd, 1'b1, t, b);
    nak = a | b;
    if (rd) begin
      start();
      xbyte({`TFR_BUS_ADDR, 1'b1}, 1'b1, t, a);
      xbyte(8'hFF, 1'b0, lo, b);
      xbyte(8'hFF, 1'b1, hi, b);
      nak = nak | a;
    end else begin
      for (int i = 0; i < nb; i++) xbyte(d[8 * i +: 8], 1'b1, t, a);
    end
    w(1);
    sda_drv <= 1'b0;
    w(3);
    scl <= 1'b1;
    w(4);
    sda_drv <= 1'b1;
    w(8);
    q = {hi, lo};
  endtask
endmodule

// *** bench/temperature_fault_response_tb_top.sv ***
`timescale 1ns/10ps

// Drives samples, controls and the host model; checks what the block reports.
module temperature_fault_response_tb_top;
  localparam int UNIT = 20;
  logic        ref_clk, resetn, scl, sda_drv, sda_out, sda_oe, temp_valid, output_on, alert_line_n;
  logic        enable_pin, bias_ok, operation_on, other_fault, ut_retry_active, nak;
  logic [15:0] temp_q4, q, v, e;
  logic [15:0] lim [2];
  logic [15:0] tbl [8] = '{16'hF2BC, 16'hF064, 16'hF2C0, 16'hF068, 16'hF7FC, 16'hF720, 16'h0, 16'hF724};
  logic [1:0]  md [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
  int          smpl [5] = '{1600, 1601, 0, -320, -321};
  int          num_errors, n_checks, seed, k, d;
  wire logic   sda_line = sda_drv & (sda_out | ~sda_oe);

  ////////////////////////////////////////
  // Clock and the parts under test.
  always #50 ref_clk = ~ref_clk;
  tfr_top #(.RETRY_UNIT_CYCLES(UNIT)) u_tfr_top (.ref_clk(ref_clk), .resetn(resetn), .scl(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .temp_q4(temp_q4), .temp_valid(temp_valid),
    .enable_pin(enable_pin), .bias_ok(bias_ok), .operation_on(operation_on), .other_fault(other_fault),
    .ut_retry_active(ut_retry_active), .output_on(output_on), .alert_line_n(alert_line_n));
  tfr_host_model u_host (.ref_clk(ref_clk), .scl(scl), .sda_drv(sda_drv), .sda_line(sda_line));

  ////////////////////////////////////////
  // Decodes an exponent and mantissa word to sixteenths of a degree.
  function automatic int q4_of(input logic [15:0] w);
    int s;
    s = int'($signed(w[15:11])) + 4;
    return (s >= 0) ? int'($signed(w[10:0])) <<< s : int'($signed(w[10:0])) >>> (-s);
  endfunction

  // Temperature status bits after one sample against warning and fault limits.
  function automatic logic [15:0] st_of(input int t);
    return {8'h0, t > 2000, t > 1600, t < -320, 5'h0};
  endfunction

  // Compares one value and counts it.
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Bus write and masked bus read.
  task automatic bus(input logic [7:0] c, input logic [15:0] dat, input int nb);
    u_host.xfer(c, dat, nb, 1'b0, q, nak);
    chk("acknowledge", 16'h0, {15'h0, nak});
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] m, input logic [15:0] exp);
    u_host.xfer(c, 16'h0, 0, 1'b1, q, nak);
    chk($sformatf("read %h", c), exp, q & m);
  endtask

  // One sample pulse, then three settling cycles.
  task automatic smp(input int t);
    temp_q4 <= 16'(t);
    temp_valid <= 1'b1;
    @(posedge ref_clk);
    temp_valid <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic chk_on(input logic exp);
    chk("output_on", 16'(exp), 16'(output_on));
  endtask

  task automatic report_and_stop();
    if (num_errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////
  // Main sequence.
  initial begin
    {ref_clk, resetn, temp_valid, other_fault, ut_retry_active} = 5'h0;
    {enable_pin, bias_ok, operation_on} = 3'h7;
    temp_q4 = 16'sh0;
    seed = 32'h854617B2;
    num_errors = 0;
    n_checks = 0;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (5) @(posedge ref_clk);
    chk_on(1'b1);
    rd(8'h50, 16'h00FF, 16'h0080);
    rd(8'h51, 16'hFFFF, 16'hEB70);
    rd(8'h52, 16'hFFFF, 16'hDC40);
    lim = '{16'hEB70, 16'hDC40};
    // Boundary and random limit words, refused ones leave the old value.
    for (k = 0; k < 10; k++) begin
      v = (k > 7 || tbl[k] == 16'h0) ? {5'h1E, 11'($random(seed))} : tbl[k];
      bus(k[0] ? 8'h52 : 8'h51, v, 2);
      d = q4_of(v);
      if (k[0] ? (d >= -880 && d <= 400) : (d >= 0 && d <= 2800)) lim[k[0]] = v;
      rd(k[0] ? 8'h52 : 8'h51, 16'hFFFF, lim[k[0]]);
    end
    bus(8'h51, 16'hF190, 2);
    bus(8'h52, 16'hF7B0, 2);
    e = 16'h0;
    foreach (smpl[i]) begin
      smp(smpl[i]);
      e = e | st_of(smpl[i]);
      rd(8'h7D, 16'h00E0, e);
      chk("alert_line_n", 16'(e == 16'h0), 16'(alert_line_n));
    end
    rd(8'h79, 16'h0004, 16'h0004);
    bus(8'h03, 16'h0, 0);
    rd(8'h7D, 16'h00E0, 16'h0);
    chk("alert_line_n", 16'h1, 16'(alert_line_n));
    foreach (md[i]) begin
      bus(8'h50, {8'h0, md[i], 6'h0}, 1);
      smp(2001);
      rd(8'h80, 16'h0002, 16'h0002);
      rd(8'h7D, 16'h0080, 16'h0080);
      smp(0);
      repeat (60) @(posedge ref_clk);
      chk_on(md[i] != 2'h2);
      bus(8'h03, 16'h0, 0);
      chk_on(1'b1);
    end
    d = $random(seed) & 7;
    bus(8'h50, {8'h0, 2'h2, 3'h1, 3'(d)}, 1);
    smp(2001);
    chk_on(1'b0);
    repeat ((d + 1) * UNIT - 10) @(posedge ref_clk);
    smp(1700);
    chk_on(1'b0);
    repeat (10) @(posedge ref_clk);
    smp(1700);
    chk_on(1'b0);
    ut_retry_active <= 1'b1;
    smp(-400);
    chk_on(1'b0);
    smp(0);
    chk_on(1'b1);
    smp(2001);
    operation_on <= 1'b0;
    repeat ((d + 1) * UNIT) @(posedge ref_clk);
    smp(0);
    chk_on(1'b0);
    operation_on <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk_on(1'b1);
    chk("alert_line_n", 16'h0, 16'(alert_line_n));
    enable_pin <= 1'b0;
    repeat (6) @(posedge ref_clk);
    chk_on(1'b0);
    enable_pin <= 1'b1;
    repeat (6) @(posedge ref_clk);
    chk_on(1'b1);
    report_and_stop();
  end
endmodule
